/* File: verilog/lvw_pkg.sv */
package lvw_pkg;
    // ==========================================================
    // widths
    localparam int unsigned SAMPLE_W = 10;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LOW_W = 2;
    localparam int unsigned SPAN_W = 2;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_LATEST_VOLTAGE_HIGH = 8'h02;
    localparam logic [7:0] OFS_LATEST_VOLTAGE_LOW = 8'h03;
    localparam logic [7:0] OFS_PEAK_CURRENT_HIGH = 8'h0A;
    localparam logic [7:0] OFS_PEAK_CURRENT_LOW = 8'h0B;
    localparam logic [7:0] OFS_VOLTAGE_SPAN_SELECT = 8'h18;
    localparam logic [7:0] OFS_LOW_VOLTAGE_WARN_HIGH = 8'h1A;
    localparam logic [7:0] OFS_LOW_VOLTAGE_WARN_LOW = 8'h1B;
    localparam logic [7:0] OFS_LOW_VOLTAGE_CRIT_HIGH = 8'h1C;
    localparam logic [7:0] OFS_LOW_VOLTAGE_CRIT_LOW = 8'h1D;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_LOW = 2'h0;
    localparam logic [9:0] RST_SAMPLE = 10'h000;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ==========================================================
    // full-scale span codes
    localparam logic [1:0] SPAN_16V = 2'h0;
    localparam logic [1:0] SPAN_8V = 2'h1;
    localparam logic [1:0] SPAN_4V = 2'h2;
    localparam logic [1:0] SPAN_2V = 2'h3;
    localparam int unsigned SPAN_16V_VOLTS = 16;
    localparam int unsigned SPAN_8V_VOLTS = 8;
    localparam int unsigned SPAN_4V_VOLTS = 4;
    localparam int unsigned SPAN_2V_VOLTS = 2;

    // ==========================================================
    // safety response codes
    localparam logic [1:0] SAFE_FULL = 2'h0;
    localparam logic [1:0] SAFE_PG = 2'h1;
    localparam logic [1:0] SAFE_ALERT = 2'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic is_current;
        logic [9:0] data;
    } lvw_sample_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lvw_reg_req_t;
endpackage

/* File: verilog/lvw_monitor.sv */
`timescale 1ns/1ps
// Contract
// (R1) each voltage sample becomes latest measurement
// (R2) software selects one of four spans
// (R3) span code 00..11 is 16,8,4,2 V
// (R4) span resets to code zero
// (R5) latest voltage readable at 0x02/0x03
// (R6) bits 9:2 high, 1:0 low
// (R7) peak current held, split, resets zero
// (R8) every voltage sample checked against four limits
// (R9) power good and outside warning drives alert low
// (R10) critical violation acts per safety code
// (R11) warning violations only ever raise alert
// (R12) low warning limit read-write, resets zero
// (R13) low critical upper byte read-write, resets zero
// (R14) any limit ordering is accepted
// (R15) codes 00,01,10 give full, pg, alert
// (R16) peak replaced by any larger current sample
// (R17) peak cleared at startup or clear command
// (R18) limits compared as full 10-bit values
// (R19) unused low-register bits read zero
module lvw_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire lvw_pkg::lvw_sample_t sample_in,
    input wire lvw_pkg::lvw_reg_req_t reg_req,
    input wire logic [1:0] safety_response_code,
    input wire logic [9:0] high_voltage_warning_limit,
    input wire logic [9:0] high_voltage_critical_limit,
    input wire logic channel_startup,
    input wire logic peak_clear,
    output logic [7:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    output logic [1:0] span_code_ff,
    output logic alert_n_ff,
    output logic power_good_out_ff,
    output logic channel_off_ff
);
    import lvw_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [9:0] join10(input logic [7:0] hi,
                                          input logic [1:0] lo);
        return {hi, lo}; // R18
    endfunction

    function automatic logic [7:0] high8(input logic [9:0] v);
        return v[9:2]; // R6
    endfunction

    function automatic logic [7:0] low8(input logic [9:0] v);
        return {6'h00, v[1:0]}; // R6 R19
    endfunction

    // full-scale volts for a span code, used only by the span decode check
    function automatic int unsigned span_volts(input logic [1:0] c);
        int unsigned v;
        v = SPAN_16V_VOLTS;
        case (c)
            SPAN_16V: v = SPAN_16V_VOLTS; // R3
            SPAN_8V: v = SPAN_8V_VOLTS;
            SPAN_4V: v = SPAN_4V_VOLTS;
            default: v = SPAN_2V_VOLTS;
        endcase
        return v;
    endfunction

    // ==========================================================
    // register storage
    logic [9:0] latest_voltage_ff;
    logic [9:0] peak_current_ff;
    logic [7:0] low_warn_high_ff;
    logic [1:0] low_warn_field_ff;
    logic [7:0] low_crit_high_ff;
    logic [1:0] low_crit_field_ff;
    logic volt_sample;
    logic curr_sample;
    logic wr_hit;

    assign volt_sample = sample_in.valid && !sample_in.is_current;
    assign curr_sample = sample_in.valid && sample_in.is_current;
    assign wr_hit = reg_req.wr;

    // latest voltage follows every voltage sample
    always_ff @(posedge clock) begin
        if (reset) begin
            latest_voltage_ff <= RST_SAMPLE; // R5
        end else if (volt_sample) begin
            latest_voltage_ff <= sample_in.data; // R1
        end
    end

    // a coincident sample beats the clear so no peak is lost
    always_ff @(posedge clock) begin
        if (reset) begin
            peak_current_ff <= RST_SAMPLE; // R7
        end else if (curr_sample &&
                     (channel_startup || peak_clear ||
                      sample_in.data > peak_current_ff)) begin
            peak_current_ff <= sample_in.data; // R16
        end else if (channel_startup || peak_clear) begin
            peak_current_ff <= RST_SAMPLE; // R17
        end
    end

    // writable registers; only defined bits are stored
    always_ff @(posedge clock) begin
        if (reset) begin
            span_code_ff <= SPAN_16V; // R4
            low_warn_high_ff <= RST_BYTE; // R12
            low_warn_field_ff <= RST_LOW;
            low_crit_high_ff <= RST_BYTE; // R13
            low_crit_field_ff <= RST_LOW;
        end else if (wr_hit) begin
            if (reg_req.addr == OFS_VOLTAGE_SPAN_SELECT) begin
                span_code_ff <= reg_req.wdata[1:0]; // R2
            end else if (reg_req.addr == OFS_LOW_VOLTAGE_WARN_HIGH) begin
                low_warn_high_ff <= reg_req.wdata; // R12
            end else if (reg_req.addr == OFS_LOW_VOLTAGE_WARN_LOW) begin
                low_warn_field_ff <= reg_req.wdata[1:0]; // R19
            end else if (reg_req.addr == OFS_LOW_VOLTAGE_CRIT_HIGH) begin
                low_crit_high_ff <= reg_req.wdata; // R13
            end else if (reg_req.addr == OFS_LOW_VOLTAGE_CRIT_LOW) begin
                low_crit_field_ff <= reg_req.wdata[1:0];
            end
        end
    end

    // ==========================================================
    // read port: data one cycle after the read strobe
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = READ_UNMAPPED;
        if (reg_req.addr == OFS_LATEST_VOLTAGE_HIGH) begin
            nxt_rdata = high8(latest_voltage_ff); // R5
        end else if (reg_req.addr == OFS_LATEST_VOLTAGE_LOW) begin
            nxt_rdata = low8(latest_voltage_ff);
        end else if (reg_req.addr == OFS_PEAK_CURRENT_HIGH) begin
            nxt_rdata = high8(peak_current_ff); // R7
        end else if (reg_req.addr == OFS_PEAK_CURRENT_LOW) begin
            nxt_rdata = low8(peak_current_ff);
        end else if (reg_req.addr == OFS_VOLTAGE_SPAN_SELECT) begin
            nxt_rdata = {6'h00, span_code_ff};
        end else if (reg_req.addr == OFS_LOW_VOLTAGE_WARN_HIGH) begin
            nxt_rdata = low_warn_high_ff;
        end else if (reg_req.addr == OFS_LOW_VOLTAGE_WARN_LOW) begin
            nxt_rdata = {6'h00, low_warn_field_ff}; // R19
        end else if (reg_req.addr == OFS_LOW_VOLTAGE_CRIT_HIGH) begin
            nxt_rdata = low_crit_high_ff;
        end else if (reg_req.addr == OFS_LOW_VOLTAGE_CRIT_LOW) begin
            nxt_rdata = {6'h00, low_crit_field_ff};
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata_ff <= RST_BYTE;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // ==========================================================
    // window comparators
    logic [9:0] low_warning_limit;
    logic [9:0] low_critical_limit;
    logic out_warn;
    logic out_crit;
    logic in_crit;
    logic [1:0] safe_code;

    // limits are never checked against each other, any order works
    assign low_warning_limit = join10(low_warn_high_ff,
                                      low_warn_field_ff); // R18 R14
    assign low_critical_limit = join10(low_crit_high_ff,
                                       low_crit_field_ff);
    assign out_warn = (sample_in.data < low_warning_limit) ||
                      (sample_in.data > high_voltage_warning_limit); // R8
    assign out_crit = (sample_in.data < low_critical_limit) ||
                      (sample_in.data > high_voltage_critical_limit);
    assign in_crit = !out_crit;
    // code 11 is undefined; treated as the mildest response
    assign safe_code = (safety_response_code == SAFE_FULL ||
                        safety_response_code == SAFE_PG) ?
                       safety_response_code : SAFE_ALERT;

    // power good follows the critical window unless told to keep it
    always_ff @(posedge clock) begin
        if (reset) begin
            power_good_out_ff <= 1'b0;
        end else if (volt_sample) begin
            if (in_crit) begin
                power_good_out_ff <= 1'b1;
            end else if (safe_code != SAFE_ALERT) begin
                power_good_out_ff <= 1'b0; // R10 R15
            end
        end
    end

    // alert is a level re-evaluated on every voltage sample
    always_ff @(posedge clock) begin
        if (reset) begin
            alert_n_ff <= 1'b1;
        end else if (volt_sample) begin
            alert_n_ff <= !((power_good_out_ff && out_warn) ||
                            out_crit); // R9 R11 R15
        end
    end

    // shutdown latches; only a channel restart releases it
    always_ff @(posedge clock) begin
        if (reset) begin
            channel_off_ff <= 1'b0;
        end else if (volt_sample && out_crit && safe_code == SAFE_FULL) begin
            channel_off_ff <= 1'b1; // R10 R15
        end else if (channel_startup) begin
            channel_off_ff <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    sequence s_crit_full;
        volt_sample && out_crit && safe_code == SAFE_FULL;
    endsequence

    a_latest_follow: assert property (@(posedge clock) disable iff (reset)
        volt_sample |=> latest_voltage_ff == $past(sample_in.data)) // R1
        else $error("latest voltage missed a sample");
    a_span_write: assert property (@(posedge clock) disable iff (reset)
        wr_hit && reg_req.addr == OFS_VOLTAGE_SPAN_SELECT |=>
        span_code_ff == $past(reg_req.wdata[1:0])) // R2
        else $error("span write lost");
    a_span_decode: assert property (@(posedge clock) disable iff (reset)
        span_volts(span_code_ff) ==
        (SPAN_16V_VOLTS >> span_code_ff)) // R3
        else $error("span decode wrong");
    a_split_read: assert property (@(posedge clock) disable iff (reset)
        reg_req.rd && reg_req.addr == OFS_LATEST_VOLTAGE_LOW |=>
        reg_rdata_ff == {6'h00, $past(latest_voltage_ff[1:0])}) // R6 R19
        else $error("low half read wrong");
    a_peak_grow: assert property (@(posedge clock) disable iff (reset)
        curr_sample && sample_in.data > peak_current_ff |=>
        peak_current_ff == $past(sample_in.data)) // R16
        else $error("peak not updated");
    a_peak_clear: assert property (@(posedge clock) disable iff (reset)
        (channel_startup || peak_clear) && !curr_sample |=>
        peak_current_ff == RST_SAMPLE) // R17
        else $error("peak not cleared");
    a_alert_warn: assert property (@(posedge clock) disable iff (reset)
        volt_sample && power_good_out_ff && out_warn |=> !alert_n_ff) // R9
        else $error("alert missing on warning");
    a_warn_only: assert property (@(posedge clock) disable iff (reset)
        volt_sample && !out_crit |=> power_good_out_ff &&
        ($stable(channel_off_ff) || $past(channel_startup))) // R11
        else $error("warning acted beyond alert");
    a_crit_shut: assert property (@(posedge clock) disable iff (reset)
        s_crit_full |=> channel_off_ff && !power_good_out_ff
        ##1 channel_off_ff || $past(channel_startup)) // R10 R15
        else $error("critical shutdown missing");
    a_alert_keep_pg: assert property (@(posedge clock) disable iff (reset)
        volt_sample && out_crit && safe_code == SAFE_ALERT |=>
        $stable(power_good_out_ff) && !alert_n_ff) // R15
        else $error("alert-only code changed power good");
endmodule

/* File: bench/lvw_host_model.sv */
`timescale 1ns/1ps
// ============================================================
// host side of the register strobe port
module lvw_host_model (
    input wire logic clock,
    output lvw_pkg::lvw_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic reg_rvalid_ff
);
    import lvw_pkg::*;

    // strobes idle low; address and data park on an inverted value
    // so a design that samples them outside a strobe sees junk
    initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 8'hFF};

    // one-cycle write strobe; the design takes it at the next edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // read answer stands one cycle after the strobe edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        @(posedge clock);
        #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hFF};
        @(posedge clock);
        #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h00};
        ok = reg_rvalid_ff;
        d = reg_rdata_ff;
    endtask
endmodule

/* File: bench/test_lvw_monitor.sv */
`timescale 1ns/1ps
// ============================================================
// register-level tests of the load voltage window monitor
module test_lvw_monitor;
    import lvw_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    lvw_sample_t sample_in = '0;
    lvw_reg_req_t reg_req;
    logic [1:0] safety_response_code = SAFE_FULL;
    logic [9:0] hv_warn = 10'h300;
    logic [9:0] hv_crit = 10'h380;
    logic channel_startup = 1'b0;
    logic peak_clear = 1'b0;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] span;
    logic alert_n;
    logic pg;
    logic off;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] ofs [9] = '{8'h02, 8'h03, 8'h0A, 8'h0B, 8'h18, 8'h1A,
                            8'h1B, 8'h1C, 8'h40};

    lvw_monitor DUT (.clock(clock), .reset(reset), .sample_in(sample_in),
        .reg_req(reg_req), .safety_response_code(safety_response_code),
        .high_voltage_warning_limit(hv_warn),
        .high_voltage_critical_limit(hv_crit),
        .channel_startup(channel_startup), .peak_clear(peak_clear),
        .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .span_code_ff(span),
        .alert_n_ff(alert_n), .power_good_out_ff(pg),
        .channel_off_ff(off));

    lvw_host_model host (.clock(clock), .reg_req(reg_req),
        .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid));

    initial forever #5 clock = ~clock;

    // ========================================================
    // shared helpers
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.read_reg(a, d, ok);
        chk({9'h000, ok}, 10'h001);
        chk({2'h0, d}, {2'h0, exp});
    endtask

    // one sample, valid for a single cycle; outputs settle at the end
    task automatic smp(input logic c, input logic [9:0] d);
        @(posedge clock);
        #1 sample_in = '{valid: 1'b1, is_current: c, data: d};
        @(posedge clock);
        #1 sample_in = '{valid: 1'b0, is_current: c, data: ~d};
    endtask

    task automatic pls(input logic start);
        @(posedge clock);
        #1;
        if (start) begin
            channel_startup = 1'b1;
        end else begin
            peak_clear = 1'b1;
        end
        @(posedge clock);
        #1 channel_startup = 1'b0;
        peak_clear = 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard at 20000 cycles, far beyond the 140 or so cycles the tests need
    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    // ========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        #1 reset = 1'b0;
        for (int i = 0; i < 9; i++) rd(ofs[i], RST_BYTE);
        chk({8'h00, span}, {8'h00, SPAN_16V});
        chk({7'h00, alert_n, pg, off}, 10'h004);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            host.write_reg(OFS_VOLTAGE_SPAN_SELECT, {6'h3F, k[1:0]});
            chk({8'h00, span}, {8'h00, k[1:0]});
            rd(OFS_VOLTAGE_SPAN_SELECT, {6'h00, k[1:0]});
        end
        host.write_reg(OFS_LOW_VOLTAGE_WARN_HIGH, 8'h40);
        host.write_reg(OFS_LOW_VOLTAGE_WARN_LOW, 8'hFE);
        host.write_reg(OFS_LOW_VOLTAGE_CRIT_HIGH, 8'h20);
        host.write_reg(OFS_LATEST_VOLTAGE_HIGH, 8'h77);
        rd(OFS_LOW_VOLTAGE_WARN_HIGH, 8'h40);
        rd(OFS_LOW_VOLTAGE_WARN_LOW, 8'h02);
        rd(OFS_LOW_VOLTAGE_CRIT_HIGH, 8'h20);
        // companion low bits make the low critical limit 0x081
        host.write_reg(OFS_LOW_VOLTAGE_CRIT_LOW, 8'hFD);
        rd(OFS_LOW_VOLTAGE_CRIT_LOW, 8'h01);
        rd(OFS_LATEST_VOLTAGE_HIGH, RST_BYTE);
        $display("test register access done");
        smp(1'b0, 10'h2D7);
        rd(OFS_LATEST_VOLTAGE_HIGH, 8'hB5);
        rd(OFS_LATEST_VOLTAGE_LOW, 8'h03);
        // warn limit is 0x102: 0x101 trips only through its low bits
        smp(1'b0, 10'h101);
        chk({8'h00, alert_n, pg}, 10'h001);
        smp(1'b0, 10'h101);
        chk({7'h00, alert_n, pg, off}, 10'h002);
        smp(1'b0, 10'h102);
        chk({8'h00, alert_n, pg}, 10'h003);
        smp(1'b0, 10'h340);
        chk({7'h00, alert_n, pg, off}, 10'h002);
        $display("test warning limits done");
        // code 11 is handled like the alert-only code
        for (int k = 0; k < 4; k++) begin
            safety_response_code = k[1:0];
            pls(1'b1);
            chk({9'h000, off}, 10'h000);
            smp(1'b0, 10'h200);
            smp(1'b0, 10'h3A0);
            chk({8'h00, alert_n, pg}, {9'h000, k >= 2});
            chk({9'h000, off}, {9'h000, k == 0});
        end
        safety_response_code = SAFE_FULL;
        pls(1'b1);
        smp(1'b0, 10'h200);
        smp(1'b0, 10'h07F);
        chk({7'h00, alert_n, pg, off}, 10'h001);
        $display("test critical limits done");
        pls(1'b1);
        smp(1'b1, 10'h155);
        smp(1'b1, 10'h0AA);
        rd(OFS_PEAK_CURRENT_HIGH, 8'h55);
        rd(OFS_PEAK_CURRENT_LOW, 8'h01);
        smp(1'b1, 10'h3FF);
        rd(OFS_PEAK_CURRENT_HIGH, 8'hFF);
        rd(OFS_PEAK_CURRENT_LOW, 8'h03);
        pls(1'b0);
        rd(OFS_PEAK_CURRENT_HIGH, RST_BYTE);
        smp(1'b1, 10'h0C1);
        pls(1'b1);
        rd(OFS_PEAK_CURRENT_LOW, RST_BYTE);
        $display("test peak current done");
        complete_run();
    end
endmodule
